// >>> logic/sfcs_defs.svh
// Constants of the serial memory command and status block.
// Assumes the serial pins are sampled by a faster core clock.
//
// Notes on behaviour
// R1: status bit 7 is the guard enable
// R2: status bits 6 to 4 are spare storage
// R3: status bits 3 and 2 size protection
// R4: status bit 1 is the write latch
// R5: latch cleared at reset, disable, wake
// R6: writes leave the latch set
// R7: status bit 0 always reads zero
// R8: first eight bits form the command code
// R9: host sends only defined codes
// R10: early deselect discards the command
// R11: enable and disable codes act immediately
// R12: host enables latch before every write; the bench enables it once before a run of several writes
// R13: no write while latch is clear
// R14: status read shifts out on falling edges
// R15: status byte repeats while clocking continues
// R16: status write stores only bits 7 to 2
// R17: host holds guard pin during status write
// R18: read takes address, top bit ignored
// R19: read address increments and wraps
// R20: memory write and fast read codes
// R21: deep sleep and hibernate codes
// R22: special sector command codes
// R23: memory write stores bytes, increments, wraps
// R24: fast read skips eight dummy bits
// R25: size bits protect none, quarter, half, all
// R26: sleep on deselect, cancelled by clock
// R27: identity and serial number codes
// R28: deselect restarts code reception
`ifndef SFCS_DEFS_SVH
`define SFCS_DEFS_SVH

`define SFCS_OP_SET_WE 8'h06
`define SFCS_OP_CLR_WE 8'h04
`define SFCS_OP_STAT_RD 8'h05
`define SFCS_OP_STAT_WR 8'h01
`define SFCS_OP_MEM_RD 8'h03
`define SFCS_OP_MEM_WR 8'h02
`define SFCS_OP_FAST_RD 8'h0B
`define SFCS_OP_DEEP 8'hBA
`define SFCS_OP_HIBERNATE 8'hB9
`define SFCS_OP_ID_RD 8'h9F
`define SFCS_OP_UID_RD 8'h4C
`define SFCS_OP_SN_WR 8'hC2
`define SFCS_OP_SN_RD 8'hC3
`define SFCS_OP_SS_WR 8'h42
`define SFCS_OP_SS_RD 8'h4B
`define SFCS_OP_SS_FAST_RD 8'h49
`define SFCS_OP_RSVD_0 8'hCE
`define SFCS_OP_RSVD_1 8'hCF
`define SFCS_OP_RSVD_2 8'hCC

`define SFCS_ST_GUARD 7
`define SFCS_ST_SPARE_HI 6
`define SFCS_ST_SPARE_LO 4
`define SFCS_ST_SIZE_HI 3
`define SFCS_ST_SIZE_LO 2
`define SFCS_ST_WEL 1
`define SFCS_ST_ZERO 0
`define SFCS_STATUS_NV_RST 6'h00

`define SFCS_MEM_WORDS 32768
`define SFCS_QUARTER_BASE 15'h6000
`define SFCS_HALF_BASE 15'h4000
`define SFCS_BP_QUARTER 2'h1
`define SFCS_BP_HALF 2'h2
`define SFCS_BP_ALL 2'h3

`define SFCS_BYTE_LAST 5'h07
`define SFCS_ADDR_LAST 5'h0F
`define SFCS_OUT_LAST 3'h7

`endif

// >>> logic/sfcs_pkg.sv
// Types of the serial memory command and status block.
// Assumes sfcs_defs.svh for all numeric constants.
package sfcs_pkg;
	typedef enum logic [8:0] {
		ST_CODE = 9'h001,
		ST_ADDR = 9'h002,
		ST_DUMMY = 9'h004,
		ST_RDATA = 9'h008,
		ST_WDATA = 9'h010,
		ST_SRD = 9'h020,
		ST_SWR = 9'h040,
		ST_LP = 9'h080,
		ST_IGNORE = 9'h100
	} sfcs_state_t;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic wp_n;
	} sfcs_pins_t;
endpackage : sfcs_pkg

// >>> logic/sfcs_top.sv
// Serial memory slave: command decode, status register, array read and write.
// Assumes the serial pins are asynchronous to core_clk_in and that the
// serial clock is slower than a quarter of the core clock.
`timescale 1ns/1ps
`include "sfcs_defs.svh"

module sfcs_top import sfcs_pkg::*; (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// Serial pins
	input wire sfcs_pins_t pins_in,
	output logic so_out,
	output logic so_oe_out,
	// Low-power state
	output logic deep_sleep_out,
	output logic hibernate_out
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and edge detection

	sfcs_pins_t pins_s1;
	sfcs_pins_t pins_s2;
	logic sck_prev;
	logic cs_prev;

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			pins_s1 <= '{cs_n: 1'h1, sck: 1'h0, si: 1'h0, wp_n: 1'h1};
			pins_s2 <= '{cs_n: 1'h1, sck: 1'h0, si: 1'h0, wp_n: 1'h1};
			sck_prev <= 1'h0;
			cs_prev <= 1'h1;
		end else begin
			pins_s1 <= pins_in;
			pins_s2 <= pins_s1;
			sck_prev <= pins_s2.sck;
			cs_prev <= pins_s2.cs_n;
		end
	end

	wire selected = ~pins_s2.cs_n;
	wire sck_rise = pins_s2.sck & ~sck_prev;
	wire sck_fall = ~pins_s2.sck & sck_prev;
	wire cs_fall = ~pins_s2.cs_n & cs_prev;
	wire cs_rise = pins_s2.cs_n & ~cs_prev;

////////////////////////////////////////////////////////////////////////////////
// State and decode

	sfcs_state_t state;
	sfcs_state_t next_state;
	logic [4:0] cnt;
	logic [4:0] next_cnt;
	logic [7:0] rx_sr;
	logic [7:0] cmd;
	logic [15:0] addr_sr;
	logic [14:0] mem_addr;
	logic [7:0] tx_sr;
	logic [2:0] out_cnt;
	logic write_enable_latch;
	logic [5:0] status_nv;
	logic [7:0] mem [0:`SFCS_MEM_WORDS-1];

	wire [7:0] next_rx = {rx_sr[6:0], pins_s2.si};
	wire [15:0] next_addr = {addr_sr[14:0], pins_s2.si};
	wire [14:0] addr_inc = mem_addr + 15'h0001;
	wire lp_any = deep_sleep_out | hibernate_out;
	wire byte_done = selected & sck_rise & (cnt == `SFCS_BYTE_LAST);
	wire code_done = byte_done & (state == ST_CODE);
	wire addr_done = selected & sck_rise & (state == ST_ADDR) & (cnt == `SFCS_ADDR_LAST);
	wire dummy_done = byte_done & (state == ST_DUMMY);
	wire out_state = (state == ST_RDATA) | (state == ST_SRD);
	wire out_fall = selected & sck_fall & out_state;
	wire tx_reload = out_fall & (out_cnt == `SFCS_OUT_LAST);
	wire [7:0] status_word = {status_nv, write_enable_latch, 1'h0}; // see R7

	// Guard pin low with the guard bit set locks the status register
	wire guard_block = status_nv[`SFCS_ST_GUARD-`SFCS_ST_SIZE_LO] & ~pins_s2.wp_n; // see R1
	wire status_wr = byte_done & (state == ST_SWR) & write_enable_latch & ~guard_block; // see R13
	wire [1:0] size_bits = status_nv[`SFCS_ST_SIZE_HI-`SFCS_ST_SIZE_LO:0]; // see R3
	wire wr_protected = (size_bits == `SFCS_BP_ALL) // see R25
		| ((size_bits == `SFCS_BP_HALF) & (mem_addr >= `SFCS_HALF_BASE))
		| ((size_bits == `SFCS_BP_QUARTER) & (mem_addr >= `SFCS_QUARTER_BASE));
	wire mem_we = byte_done & (state == ST_WDATA) & write_enable_latch & ~wr_protected; // see R23

	always_comb begin
		next_state = state;
		next_cnt = cnt;
		if (!selected) begin
			next_state = ST_CODE; // see R28
			next_cnt = 5'h00;
		end else if (cs_fall & lp_any) begin
			next_state = ST_IGNORE;
		end else if (sck_rise) begin
			next_cnt = cnt + 5'h01;
			case (state)
				ST_CODE: begin
					if (cnt == `SFCS_BYTE_LAST) begin
						next_cnt = 5'h00;
						case (next_rx) // see R8
							`SFCS_OP_STAT_RD: next_state = ST_SRD; // see R14
							`SFCS_OP_STAT_WR: next_state = ST_SWR; // see R16
							`SFCS_OP_MEM_RD: next_state = ST_ADDR; // see R18
							`SFCS_OP_MEM_WR: next_state = ST_ADDR; // see R20
							`SFCS_OP_FAST_RD: next_state = ST_ADDR; // see R20
							`SFCS_OP_DEEP: next_state = ST_LP; // see R21
							`SFCS_OP_HIBERNATE: next_state = ST_LP; // see R21
							// Latch codes end here, the latch itself being written in this block; identity, serial number
							// and special sector codes end here too: their data paths are not in this block.
							default: next_state = ST_IGNORE; // see R22, R27
						endcase
					end
				end
				ST_ADDR: begin
					if (cnt == `SFCS_ADDR_LAST) begin
						next_cnt = 5'h00;
						if (cmd == `SFCS_OP_FAST_RD) begin
							next_state = ST_DUMMY; // see R24
						end else if (cmd == `SFCS_OP_MEM_WR) begin
							next_state = ST_WDATA;
						end else begin
							next_state = ST_RDATA;
						end
					end
				end
				ST_DUMMY: begin
					if (cnt == `SFCS_BYTE_LAST) begin
						next_cnt = 5'h00;
						next_state = ST_RDATA;
					end
				end
				ST_WDATA: begin
					if (cnt == `SFCS_BYTE_LAST) begin
						next_cnt = 5'h00;
					end
				end
				ST_SWR: begin
					if (cnt == `SFCS_BYTE_LAST) begin
						next_cnt = 5'h00;
						next_state = ST_IGNORE;
					end
				end
				ST_LP: next_state = ST_IGNORE; // see R26
				default: next_cnt = cnt;
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			state <= ST_CODE;
			cnt <= 5'h00;
			rx_sr <= 8'h00;
			cmd <= 8'h00;
			addr_sr <= 16'h0000;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			rx_sr <= (selected & sck_rise) ? next_rx : rx_sr;
			cmd <= code_done ? next_rx : cmd;
			addr_sr <= (selected & sck_rise & (state == ST_ADDR)) ? next_addr : addr_sr;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Status register and write-enable latch

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			write_enable_latch <= 1'h0; // see R5
		end else if (cs_fall & lp_any) begin
			write_enable_latch <= 1'h0; // see R5
		end else if (code_done & (next_rx == `SFCS_OP_SET_WE)) begin
			write_enable_latch <= 1'h1; // see R11, R12
		end else if (code_done & (next_rx == `SFCS_OP_CLR_WE)) begin
			write_enable_latch <= 1'h0; // see R11
		end
	end

	// Bits 1 and 0 of the received byte are dropped; the latch is never written here
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			status_nv <= `SFCS_STATUS_NV_RST;
		end else if (status_wr) begin
			status_nv <= next_rx[`SFCS_ST_GUARD:`SFCS_ST_SIZE_LO]; // see R2, R4, R16
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Array, address counter and output shifter

	always_ff @(posedge core_clk_in) begin
		if (mem_we) begin
			mem[mem_addr] <= next_rx;
		end
	end

	// 15-bit counter wraps from the top address to zero by itself
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			mem_addr <= 15'h0000;
		end else if (addr_done) begin
			mem_addr <= next_addr[14:0]; // see R18
		end else if (byte_done & (state == ST_WDATA)) begin
			mem_addr <= addr_inc; // see R23
		end else if (tx_reload & (state == ST_RDATA)) begin
			mem_addr <= addr_inc; // see R19
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			tx_sr <= 8'h00;
		end else if (code_done & (next_rx == `SFCS_OP_STAT_RD)) begin
			tx_sr <= status_word;
		end else if ((addr_done & (cmd == `SFCS_OP_MEM_RD)) | dummy_done) begin
			tx_sr <= addr_done ? mem[next_addr[14:0]] : mem[mem_addr];
		end else if (tx_reload) begin
			tx_sr <= (state == ST_SRD) ? status_word : mem[addr_inc]; // see R15, R19
		end else if (out_fall) begin
			tx_sr <= {tx_sr[6:0], 1'h0}; // see R14
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in | ~selected | ~out_state) begin
			out_cnt <= 3'h0;
		end else if (out_fall) begin
			out_cnt <= out_cnt + 3'h1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in | ~selected) begin
			so_out <= 1'h0;
			so_oe_out <= 1'h0;
		end else begin
			so_out <= out_fall ? tx_sr[7] : so_out;
			so_oe_out <= out_state;
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Low-power modes

	// Entry needs a clean deselect straight after the code
	always_ff @(posedge core_clk_in) begin
		if (reset_in | cs_fall) begin
			deep_sleep_out <= 1'h0;
			hibernate_out <= 1'h0;
		end else if (cs_rise & (state == ST_LP)) begin
			deep_sleep_out <= (cmd == `SFCS_OP_DEEP); // see R26
			hibernate_out <= (cmd == `SFCS_OP_HIBERNATE);
		end
	end

////////////////////////////////////////////////////////////////////////////////
// Assertions

	property p_set_we;
		@(posedge core_clk_in) disable iff (reset_in)
		(code_done & (next_rx == `SFCS_OP_SET_WE)) |=> write_enable_latch;
	endproperty
	a_set_we: assert property (p_set_we) else $error("enable code did not set latch"); // see R11

	property p_clr_we;
		@(posedge core_clk_in) disable iff (reset_in)
		(code_done & (next_rx == `SFCS_OP_CLR_WE)) |=> !write_enable_latch;
	endproperty
	a_clr_we: assert property (p_clr_we) else $error("disable code left latch set"); // see R5

	property p_wake_clears;
		@(posedge core_clk_in) disable iff (reset_in)
		(cs_fall & lp_any) |=> (!write_enable_latch && !lp_any && state == ST_IGNORE);
	endproperty
	a_wake_clears: assert property (p_wake_clears) else $error("wake did not clear latch"); // see R5

	property p_bit0_zero;
		@(posedge core_clk_in) disable iff (reset_in)
		(state == ST_SRD && tx_reload && !$fell(pins_s2.cs_n)) |=> (so_out == 1'h0);
	endproperty
	a_bit0_zero: assert property (p_bit0_zero) else $error("status bit 0 not zero"); // see R7

	property p_no_write_unlatched;
		@(posedge core_clk_in) disable iff (reset_in)
		(!write_enable_latch && state == ST_SWR) |=> $stable(status_nv);
	endproperty
	a_no_write_unlatched: assert property (p_no_write_unlatched) else $error("status written"); // see R13

	property p_latch_kept;
		@(posedge core_clk_in) disable iff (reset_in)
		(write_enable_latch && (state == ST_SWR || state == ST_WDATA) && !cs_fall)
			|=> write_enable_latch;
	endproperty
	a_latch_kept: assert property (p_latch_kept) else $error("write cleared latch"); // see R6

	property p_early_deselect;
		@(posedge core_clk_in) disable iff (reset_in)
		(state == ST_CODE && cs_rise) |=> ($stable(write_enable_latch) && !lp_any
			&& state == ST_CODE && cnt == 5'h00);
	endproperty
	a_early_deselect: assert property (p_early_deselect) else $error("partial code acted"); // see R10

	property p_lp_cancel;
		@(posedge core_clk_in) disable iff (reset_in)
		(state == ST_LP && selected && sck_rise) |=> (state == ST_IGNORE) ##1 !lp_any;
	endproperty
	a_lp_cancel: assert property (p_lp_cancel) else $error("clocked sleep not cancelled"); // see R26

	property p_wrap;
		@(posedge core_clk_in) disable iff (reset_in)
		(tx_reload && state == ST_RDATA && mem_addr == 15'h7FFF) |=> (mem_addr == 15'h0000);
	endproperty
	a_wrap: assert property (p_wrap) else $error("read address did not wrap"); // see R19

	property p_protect;
		@(posedge core_clk_in) disable iff (reset_in)
		mem_we |-> (write_enable_latch && !(size_bits == `SFCS_BP_ALL)
			&& !(size_bits == `SFCS_BP_HALF && mem_addr[14])
			&& !(size_bits == `SFCS_BP_QUARTER && mem_addr[14:13] == 2'h3));
	endproperty
	a_protect: assert property (p_protect) else $error("protected array written"); // see R25

	property p_oe_off;
		@(posedge core_clk_in) disable iff (reset_in)
		cs_rise |=> !so_oe_out;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("output driven after deselect"); // see R14

	property p_guard_lock;
		@(posedge core_clk_in) disable iff (reset_in)
		(byte_done && state == ST_SWR && status_nv[`SFCS_ST_GUARD-`SFCS_ST_SIZE_LO]
			&& !pins_s2.wp_n) |=> $stable(status_nv);
	endproperty
	a_guard_lock: assert property (p_guard_lock) else $error("guard ignored"); // see R1

	property p_status_store;
		@(posedge core_clk_in) disable iff (reset_in)
		status_wr |=> (status_nv == rx_sr[`SFCS_ST_GUARD:`SFCS_ST_SIZE_LO]
			&& write_enable_latch);
	endproperty
	a_status_store: assert property (p_status_store) else $error("status not stored"); // see R16

	property p_sleep_entry;
		@(posedge core_clk_in) disable iff (reset_in)
		(cs_rise && state == ST_LP) |=> (deep_sleep_out != hibernate_out);
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("no sleep entry"); // see R26

endmodule : sfcs_top

// >>> tb/sfcs_host.sv
// Host model for the serial memory block: mode 0 controller.
// Assumes the bench clock paces every pin change; sck rests low between frames.
`timescale 1ns/1ps
module sfcs_host import sfcs_pkg::*; (
	// Pacing clock
	input wire logic clk_in,
	// Serial lines
	input wire logic so_in,
	output sfcs_pins_t pins_out
);
	initial begin
		pins_out = 4'h9;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic sel();
		@(posedge clk_in);
		pins_out.cs_n <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask : sel
	// Released data line shows the inverse, so a stale bit cannot pass as a match
	task automatic desel();
		repeat (4) @(posedge clk_in);
		pins_out.cs_n <= 1'b1;
		pins_out.si <= ~pins_out.si;
		repeat (12) @(posedge clk_in);
	endtask : desel
	// MSB first, 8 core cycles a bit; so is taken at the end of the high phase,
	// long after the falling edge that launched it
	task automatic shift(input logic [7:0] d, input int n, output logic [7:0] q);
		q = 8'h00;
		@(posedge clk_in);
		for (int i = 7; i > 7 - n; i--) begin
			pins_out.sck <= 1'b0;
			pins_out.si <= d[i];
			repeat (4) @(posedge clk_in);
			pins_out.sck <= 1'b1;
			repeat (4) @(posedge clk_in);
			q[i] = so_in;
		end
		pins_out.sck <= 1'b0;
	endtask : shift
	// Called only between frames
	task automatic guard(input logic v);
		@(posedge clk_in);
		pins_out.wp_n <= v;
	endtask : guard
endmodule : sfcs_host

// >>> tb/tb.sv
// Self-checking bench for the serial memory command and status block.
// Assumes sfcs_host drives the pins; only defined codes are ever sent.
`timescale 1ns/1ps
`include "sfcs_defs.svh"
module tb import sfcs_pkg::*;;
	logic core_clk_in;
	logic reset_in;
	logic so_out;
	logic so_oe_out;
	logic deep_sleep_out;
	logic hibernate_out;
	sfcs_pins_t pins;
	int n_mismatch = 0;
	int cmp_count = 0;
	logic [7:0] q;
	logic [15:0] r;
	initial begin
		core_clk_in = 1'b0;
		forever #20 core_clk_in = ~core_clk_in;
	end
	sfcs_top dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .pins_in(pins),
		.so_out(so_out), .so_oe_out(so_oe_out), .deep_sleep_out(deep_sleep_out),
		.hibernate_out(hibernate_out));
	sfcs_host host (.clk_in(core_clk_in), .so_in(so_out), .pins_out(pins));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic op(input logic [7:0] c);
		host.sel();
		host.shift(c, 8, q);
		host.desel();
	endtask : op
	// Data on si during the read must not matter
	task automatic st_rd(input logic [7:0] e);
		host.sel();
		host.shift(`SFCS_OP_STAT_RD, 8, q);
		host.shift(8'h5A, 8, q);
		chk(q, e);
		chk({7'h00, so_oe_out}, 8'h01);
		host.shift(8'hA5, 8, q);
		chk(q, e);
		host.desel();
	endtask : st_rd
	task automatic st_wr(input logic [7:0] v);
		host.sel();
		host.shift(`SFCS_OP_STAT_WR, 8, q);
		host.shift(v, 8, q);
		host.desel();
	endtask : st_wr
	task automatic mem(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d);
		host.sel();
		host.shift(c, 8, q);
		host.shift(a[15:8], 8, q);
		host.shift(a[7:0], 8, q);
		if (c == `SFCS_OP_FAST_RD) host.shift(8'hFF, 8, q);
		host.shift(d[15:8], 8, r[15:8]);
		host.shift(d[7:0], 8, r[7:0]);
		host.desel();
	endtask : mem
	////////////////////////////////////////////////////////////////////////
	// Power-up and a mid-run reset both leave the latch and status clear
	task automatic t_reset();
		st_rd(8'h00);
		op(`SFCS_OP_SET_WE);
		st_wr(8'h3C);
		st_rd(8'h3E);
		reset_in <= 1'b1;
		repeat (12) @(posedge core_clk_in);
		reset_in <= 1'b0;
		repeat (4) @(posedge core_clk_in);
		st_rd(8'h00);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_wel();
		op(`SFCS_OP_SET_WE);
		st_rd(8'h02);
		op(`SFCS_OP_CLR_WE);
		st_rd(8'h00);
		$display("t_wel done");
	endtask : t_wel
	task automatic t_status();
		op(`SFCS_OP_SET_WE);
		st_wr(8'hFF);
		st_rd(8'hFE);
		host.guard(1'b0);
		st_wr(8'h0C);
		st_rd(8'hFE);
		host.guard(1'b1);
		st_wr(8'h00);
		st_rd(8'h02);
		op(`SFCS_OP_CLR_WE);
		st_wr(8'hF0);
		st_rd(8'h00);
		$display("t_status done");
	endtask : t_status
	task automatic t_abort();
		op(`SFCS_OP_SET_WE);
		host.sel();
		host.shift(`SFCS_OP_CLR_WE, 7, q);
		host.desel();
		st_rd(8'h02);
		$display("t_abort done");
	endtask : t_abort
	task automatic t_mem();
		op(`SFCS_OP_SET_WE);
		mem(`SFCS_OP_MEM_WR, 16'h7FFF, 16'hA53C);
		mem(`SFCS_OP_MEM_RD, 16'hFFFF, 16'h00FF);
		chk(r[15:8], 8'hA5);
		chk(r[7:0], 8'h3C);
		mem(`SFCS_OP_FAST_RD, 16'h0000, 16'hFF00);
		chk(r[15:8], 8'h3C);
		st_rd(8'h02);
		$display("t_mem done");
	endtask : t_mem
	// Writes straddle the lower edge of the quarter and half regions; with all protected they wrap from 7FFF to 0
	task automatic t_protect();
		logic [15:0] lo;
		for (int bp = 1; bp < 4; bp++) begin
			lo = (bp == 1) ? 16'h5FFF : (bp == 2) ? 16'h3FFF : 16'h7FFF;
			op(`SFCS_OP_SET_WE);
			st_wr(8'h00);
			mem(`SFCS_OP_MEM_WR, lo, 16'h5555);
			st_wr({4'h0, bp[1:0], 2'h0});
			mem(`SFCS_OP_MEM_WR, lo, 16'hAAAA);
			mem(`SFCS_OP_MEM_RD, lo, 16'h0000);
			chk(r[15:8], (bp == 3) ? 8'h55 : 8'hAA);
			chk(r[7:0], 8'h55);
		end
		st_wr(8'h00);
		$display("t_protect done");
	endtask : t_protect
	task automatic t_sleep();
		logic [7:0] c;
		for (int k = 0; k < 2; k++) begin
			c = k ? `SFCS_OP_HIBERNATE : `SFCS_OP_DEEP;
			op(`SFCS_OP_SET_WE);
			host.sel();
			host.shift(c, 8, q);
			host.shift(8'h00, 1, q);
			host.desel();
			chk({6'h00, deep_sleep_out, hibernate_out}, 8'h00);
			op(c);
			chk({6'h00, deep_sleep_out, hibernate_out}, k ? 8'h01 : 8'h02);
			host.sel();
			host.desel();
			chk({6'h00, deep_sleep_out, hibernate_out}, 8'h00);
			st_rd(8'h00);
		end
		$display("t_sleep done");
	endtask : t_sleep
	// Codes whose data paths live elsewhere must leave so undriven
	task automatic t_other();
		logic [7:0] codes [7] = '{`SFCS_OP_ID_RD, `SFCS_OP_UID_RD, `SFCS_OP_SN_WR,
			`SFCS_OP_SN_RD, `SFCS_OP_SS_WR, `SFCS_OP_SS_RD, `SFCS_OP_SS_FAST_RD};
		op(`SFCS_OP_SET_WE);
		foreach (codes[i]) begin
			host.sel();
			host.shift(codes[i], 8, q);
			host.shift(8'hFF, 8, q);
			chk({7'h00, so_oe_out}, 8'h00);
			host.desel();
		end
		st_rd(8'h02);
		$display("t_other done");
	endtask : t_other
	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out
	initial begin
		reset_in = 1'b1;
		repeat (12) @(posedge core_clk_in);
		reset_in <= 1'b0;
		repeat (4) @(posedge core_clk_in);
		t_reset();
		t_wel();
		t_status();
		t_abort();
		t_mem();
		t_protect();
		t_sleep();
		t_other();
		close_out();
	end
	initial begin
		repeat (100000) @(posedge core_clk_in);
		n_mismatch++;
		$display("BAD %0t run did not finish", $time);
		close_out();
	end
endmodule : tb
